/* File: hdl/spc_core.sv */
// Serial peripheral port core: master or slave, AXI4-Lite registers, slave link domain.
//
// Chosen here: register access over AXI4-Lite and the register addresses.
module spc_core
  import spc_pkg::*;
#(
  parameter int HALF_CYC = SPC_HALF_CYC
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address and data
  input wire logic awvalid,
  output logic awready,
  input wire logic [3:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // AXI4-Lite write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // AXI4-Lite read
  input wire logic arvalid,
  output logic arready,
  input wire logic [3:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // Serial link: clock line, data lines, slave-enable line
  input wire logic spi_sclk_in,
  output logic spi_sclk_o,
  output logic spi_sclk_oe,
  input wire logic spi_miso_i,
  output logic spi_miso_o,
  output logic spi_miso_oe,
  input wire logic spi_mosi_i,
  output logic spi_mosi_o,
  output logic spi_mosi_oe,
  input wire logic slave_enable_pin_n_i,
  output logic slave_enable_pin_n_o,
  output logic slave_enable_pin_n_oe,
  // Module clock request
  output logic clk_request_q
);
  import spc_pkg::*;

  // ----------------------------------------------------------------
  // Control and status state
  // ----------------------------------------------------------------
  logic [5:0] ctrl_q;
  logic [7:0] tx_holding_buffer_q;
  logic [7:0] rx_holding_buffer_q;
  logic tx_ready_flag_q;
  logic rx_complete_flag_q;
  logic transfer_busy_flag_q;
  logic tx_pend_q;
  logic srst, mst, cpha, cpol, stem, four;
  assign srst = ctrl_q[SPC_C_SRST];
  assign mst = ctrl_q[SPC_C_MST];
  assign cpha = ctrl_q[SPC_C_CPHA];
  assign cpol = ctrl_q[SPC_C_CPOL];
  assign stem = ctrl_q[SPC_C_STEM];
  assign four = ctrl_q[SPC_C_FOUR];

  // ----------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------
  logic aw_have_q, w_have_q;
  logic [3:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic wr_fire, rd_fire;
  assign wr_fire = aw_have_q && w_have_q && !bvalid;
  assign rd_fire = arvalid && arready;
  assign awready = !aw_have_q;
  assign wready = !w_have_q;

  // Address and data are held until both have arrived, in either order.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      aw_addr_q <= 4'h0;
      w_data_q <= 32'h0;
      w_strb_q <= 4'h0;
    end else begin
      if (awvalid && awready) begin
        aw_have_q <= 1'b1;
        aw_addr_q <= awaddr;
      end else if (wr_fire) begin
        aw_have_q <= 1'b0;
      end
      if (wvalid && wready) begin
        w_have_q <= 1'b1;
        w_data_q <= wdata;
        w_strb_q <= wstrb;
      end else if (wr_fire) begin
        w_have_q <= 1'b0;
      end
    end
  end

  // Write response; unmapped or read-only addresses answer SLVERR.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp <= SPC_RESP_OKAY;
    end else if (wr_fire) begin
      bvalid <= 1'b1;
      bresp <= (aw_addr_q == SPC_CTRL_OFS || aw_addr_q == SPC_TXB_OFS) ?
               SPC_RESP_OKAY : SPC_RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // Read channel: one read at a time, answered the cycle after it is taken.
  assign arready = !rvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata <= 32'h0;
      rresp <= SPC_RESP_OKAY;
    end else if (rd_fire) begin
      rvalid <= 1'b1;
      rresp <= SPC_RESP_OKAY;
      case (araddr)
        SPC_CTRL_OFS: rdata <= {26'h0, ctrl_q};
        SPC_STAT_OFS: rdata <= {29'h0, transfer_busy_flag_q, rx_complete_flag_q,
                                tx_ready_flag_q};
        SPC_RXB_OFS: rdata <= {24'h0, rx_holding_buffer_q};
        default: begin
          rdata <= 32'h0;
          rresp <= SPC_RESP_SLVERR;
        end
      endcase
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

  logic wr_ctrl, wr_txb, rd_rxb;
  assign wr_ctrl = wr_fire && aw_addr_q == SPC_CTRL_OFS && w_strb_q[0];
  assign wr_txb = wr_fire && aw_addr_q == SPC_TXB_OFS && w_strb_q[0] && !srst;
  assign rd_rxb = rd_fire && araddr == SPC_RXB_OFS;

  // Control word; the soft reset bit is set from reset on.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= SPC_CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_q <= w_data_q[5:0];
    end
  end

  // ----------------------------------------------------------------
  // Crossings between the link domain and aclk
  // ----------------------------------------------------------------
  logic lk_tog_q;
  logic [7:0] lk_byte_q;
  logic tog_s1_q, tog_s2_q, tog_s3_q;
  logic sel_s1_q, sel_s2_q;
  logic miso_s1_q, miso_s2_q;
  logic lk_done;
  // Toggle synchroniser for the slave byte event; the byte is stable for a whole frame.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tog_s1_q <= 1'b0;
      tog_s2_q <= 1'b0;
      tog_s3_q <= 1'b0;
      sel_s1_q <= 1'b1;
      sel_s2_q <= 1'b1;
      miso_s1_q <= 1'b0;
      miso_s2_q <= 1'b0;
    end else begin
      tog_s1_q <= lk_tog_q;
      tog_s2_q <= tog_s1_q;
      tog_s3_q <= tog_s2_q;
      sel_s1_q <= slave_enable_pin_n_i;
      sel_s2_q <= sel_s1_q;
      miso_s1_q <= spi_miso_i;
      miso_s2_q <= miso_s1_q;
    end
  end
  assign lk_done = (tog_s2_q ^ tog_s3_q) && !mst && !srst;

  // ----------------------------------------------------------------
  // Master engine (link clock made here by a divider)
  // ----------------------------------------------------------------
  spc_state_t st_q;
  logic [$clog2(HALF_CYC+1)-1:0] div_q;
  logic [3:0] half_q;
  logic [7:0] msh_q, mrx_q;
  logic tick, sample_edge, change_edge, blocked;
  assign tick = div_q == ($bits(div_q))'(HALF_CYC - 1);
  assign sample_edge = tick && (half_q[0] == cpha);
  assign change_edge = tick && (half_q[0] != cpha);
  // With four set and stem clear, another master owns the bus while the enable input is low.
  assign blocked = four && !stem && !sel_s2_q;

  always_ff @(posedge aclk) begin
    if (!aresetn || srst) begin
      st_q <= SPC_IDLE;
      div_q <= '0;
      half_q <= 4'h0;
      msh_q <= 8'h0;
      mrx_q <= 8'h0;
      spi_sclk_o <= 1'b0;
      spi_mosi_o <= 1'b0;
    end else begin
      case (st_q)
        SPC_IDLE: begin
          spi_sclk_o <= cpol;
          div_q <= '0;
          half_q <= 4'h0;
          if (mst && tx_pend_q && !blocked) begin
            st_q <= SPC_XFER;
            msh_q <= tx_holding_buffer_q;
            spi_mosi_o <= tx_holding_buffer_q[7];
          end
        end
        SPC_XFER: begin
          if (blocked) begin
            st_q <= SPC_IDLE;
          end else begin
            // Every half period is the same count, the first included.
            div_q <= tick ? '0 : div_q + 1'b1;
            if (tick) begin
              spi_sclk_o <= ~spi_sclk_o;
              half_q <= half_q + 4'h1;
              if (half_q == SPC_LAST_HALF) begin
                st_q <= SPC_DONE;
              end
            end
            if (sample_edge) begin
              mrx_q <= {mrx_q[6:0], miso_s2_q};
            end
            if (change_edge && half_q != 4'h0 && half_q != SPC_LAST_HALF) begin
              msh_q <= {msh_q[6:0], 1'b0};
              spi_mosi_o <= msh_q[6];
            end
          end
        end
        SPC_DONE: begin
          st_q <= SPC_IDLE;
        end
        default: st_q <= SPC_IDLE;
      endcase
    end
  end

  // Pin drives: clock and data out only as master, enable output only as master with stem and four set.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      spi_sclk_oe <= 1'b0;
      spi_mosi_oe <= 1'b0;
      slave_enable_pin_n_o <= 1'b1;
      slave_enable_pin_n_oe <= 1'b0;
    end else begin
      spi_sclk_oe <= mst && !srst;
      spi_mosi_oe <= mst && !srst;
      slave_enable_pin_n_oe <= mst && four && stem && !srst;
      slave_enable_pin_n_o <= !(st_q == SPC_XFER);
    end
  end

  // ----------------------------------------------------------------
  // Buffers, flags and busy
  // ----------------------------------------------------------------
  logic m_start, m_done;
  assign m_start = st_q == SPC_IDLE && mst && tx_pend_q && !blocked && !srst;
  assign m_done = st_q == SPC_DONE;

  // A new character is taken on every write with strobe bit 0 set outside soft reset, even while the buffer is still full.
  always_ff @(posedge aclk) begin
    if (!aresetn || srst) begin
      tx_holding_buffer_q <= 8'h0;
      tx_pend_q <= 1'b0;
      tx_ready_flag_q <= 1'b1;
    end else begin
      if (wr_txb) begin
        tx_holding_buffer_q <= w_data_q[7:0];
        tx_pend_q <= 1'b1;
        tx_ready_flag_q <= 1'b0;
      end else if (m_start || (lk_done && tx_pend_q)) begin
        tx_pend_q <= 1'b0;
        tx_ready_flag_q <= 1'b1;
      end
    end
  end

  // Received byte wins over a read that clears the flag in the same cycle.
  always_ff @(posedge aclk) begin
    if (!aresetn || srst) begin
      rx_holding_buffer_q <= 8'h0;
      rx_complete_flag_q <= 1'b0;
    end else if (m_done) begin
      rx_holding_buffer_q <= mrx_q;
      rx_complete_flag_q <= 1'b1;
    end else if (lk_done) begin
      rx_holding_buffer_q <= lk_byte_q;
      rx_complete_flag_q <= 1'b1;
    end else if (rd_rxb) begin
      rx_complete_flag_q <= 1'b0;
    end
  end

  // Busy is a clean level: master engine starting or active, or port selected as slave.
  logic s_active;
  assign s_active = !mst && !sel_s2_q;
  always_ff @(posedge aclk) begin
    if (!aresetn || srst) begin
      transfer_busy_flag_q <= 1'b0;
      clk_request_q <= 1'b0;
    end else begin
      transfer_busy_flag_q <= (st_q == SPC_XFER) || m_start || s_active;
      clk_request_q <= (st_q == SPC_XFER) || m_start || s_active;
    end
  end

  // ----------------------------------------------------------------
  // Slave link domain on the remote master's clock
  // ----------------------------------------------------------------
  // Sampling edge is the rising edge of this derived clock; mode bits only change under hold.
  logic lclk;
  assign lclk = spi_sclk_in ^ cpol ^ cpha;
  logic lk_hold_q;
  logic [2:0] lk_cnt_q, lk_ncnt_q;
  logic [7:0] lk_sh_q;
  logic lk_out_q;
  // Link hold lags the control word by one cycle, so a glitch of the derived clock at a
  // mode change falls inside it. Its release needs no link edge, so the first edge of a
  // frame already carries data; the remote master must idle the clock meanwhile.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lk_hold_q <= 1'b1;
    end else begin
      lk_hold_q <= srst || mst;
    end
  end
  always_ff @(posedge lclk or posedge lk_hold_q) begin
    if (lk_hold_q) begin
      lk_cnt_q <= 3'h0;
      lk_sh_q <= 8'h0;
      lk_byte_q <= 8'h0;
      lk_tog_q <= 1'b0;
    end else begin
      lk_sh_q <= {lk_sh_q[6:0], spi_mosi_i};
      lk_cnt_q <= lk_cnt_q + 3'h1;
      if (lk_cnt_q == 3'h7) begin
        lk_byte_q <= {lk_sh_q[6:0], spi_mosi_i};
        lk_tog_q <= ~lk_tog_q;
      end
    end
  end
  // Changing edge: phase 0 pre-drives bit 7, phase 1 drives it on the first edge.
  always_ff @(negedge lclk or posedge lk_hold_q) begin
    if (lk_hold_q) begin
      lk_ncnt_q <= 3'h0;
      lk_out_q <= 1'b0;
    end else begin
      lk_ncnt_q <= lk_ncnt_q + 3'h1;
      lk_out_q <= cpha ? tx_holding_buffer_q[3'h7 - lk_ncnt_q] :
                         tx_holding_buffer_q[3'h6 - lk_ncnt_q];
    end
  end
  // The data line is driven only while selected; bit 7 needs no edge in phase 0.
  assign spi_miso_o = (!cpha && lk_ncnt_q == 3'h0) ? tx_holding_buffer_q[7] : lk_out_q;
  assign spi_miso_oe = !mst && !srst && !slave_enable_pin_n_i;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_frame_end;
    st_q == SPC_XFER ##1 st_q == SPC_DONE;
  endsequence

  busy_drops_a: assert property (s_frame_end |-> ##2 !transfer_busy_flag_q
    || m_start || s_active || $past(m_start))
    else $error("busy did not drop after transfer");
  clk_req_busy_a: assert property (clk_request_q == transfer_busy_flag_q
    && (!$past(st_q == SPC_XFER && !srst) || clk_request_q))
    else $error("clock request differs from busy");
  rx_flag_set_a: assert property (m_done && !srst |=> rx_complete_flag_q)
    else $error("receive flag not set after byte");
  tx_ready_set_a: assert property (m_start && !wr_txb |=> tx_ready_flag_q)
    else $error("transmit ready not set at start");
  idle_level_a: assert property (st_q == SPC_IDLE && !srst ##1 st_q == SPC_IDLE
    && !srst |-> spi_sclk_o == $past(cpol))
    else $error("clock idle level wrong");
  srst_hold_a: assert property (srst |=> st_q == SPC_IDLE && !transfer_busy_flag_q)
    else $error("soft reset does not hold port");
  block_start_a: assert property (blocked && st_q == SPC_IDLE |=> st_q != SPC_XFER)
    else $error("transfer started while blocked");
  sel_out_a: assert property (st_q == SPC_XFER |=> !slave_enable_pin_n_o)
    else $error("enable output not active in transfer");
  abort_a: assert property (st_q == SPC_XFER && blocked && !srst |=> st_q == SPC_IDLE)
    else $error("transfer not aborted");
  first_half_a: assert property (st_q == SPC_IDLE ##1 st_q == SPC_XFER && !blocked
    |-> ($bits(div_q))'(0) == div_q)
    else $error("first half period stretched");
  // Leading edge samples in phase 0, trailing edge in phase 1.
  sample_mode_a: assert property (st_q == SPC_XFER && sample_edge
    |-> spi_sclk_o == (cpol ^ cpha))
    else $error("sampling edge wrong for phase");

endmodule : spc_core

/* File: shared/spc_pkg.sv */
// Package of constants and types for the serial peripheral port core.
package spc_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses, one word each)
  // ----------------------------------------------------------------
  localparam logic [3:0] SPC_CTRL_OFS = 4'h0;
  localparam logic [3:0] SPC_STAT_OFS = 4'h4;
  localparam logic [3:0] SPC_TXB_OFS = 4'h8;
  localparam logic [3:0] SPC_RXB_OFS = 4'hc;

  // ----------------------------------------------------------------
  // Control word field positions and reset value
  // ----------------------------------------------------------------
  localparam int SPC_C_SRST = 0;
  localparam int SPC_C_MST = 1;
  localparam int SPC_C_CPHA = 2;
  localparam int SPC_C_CPOL = 3;
  localparam int SPC_C_STEM = 4;
  localparam int SPC_C_FOUR = 5;
  localparam logic [5:0] SPC_CTRL_RST = 6'h01;

  // ----------------------------------------------------------------
  // Status field positions
  // ----------------------------------------------------------------
  localparam int SPC_S_TXRDY = 0;
  localparam int SPC_S_RXDONE = 1;
  localparam int SPC_S_BUSY = 2;

  // ----------------------------------------------------------------
  // Bus answers and timing
  // ----------------------------------------------------------------
  localparam logic [1:0] SPC_RESP_OKAY = 2'h0;
  localparam logic [1:0] SPC_RESP_SLVERR = 2'h2;
  localparam int SPC_CLK_MHZ = 100;
  localparam int SPC_HALF_NS = 50;
  localparam int SPC_HALF_CYC = (SPC_HALF_NS * SPC_CLK_MHZ) / 1000;
  localparam logic [3:0] SPC_LAST_HALF = 4'hf;

  // Master engine states.
  typedef enum logic [1:0] {SPC_IDLE, SPC_XFER, SPC_DONE} spc_state_t;

endpackage : spc_pkg

/* File: tb/spc_peer.sv */
// Behavioural far-side serial party: slave to the port as master, master to it as slave.
module spc_peer (
  // Clock and lines seen on the link
  input wire logic aclk,
  input wire logic sclk,
  input wire logic mosi,
  input wire logic miso_dut,
  // Lines driven by this party
  output logic miso,
  output logic sclk_m,
  output logic mosi_m,
  output logic sel_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic cpol = 1'b0;
  logic cpha = 1'b0;
  logic armed = 1'b0;
  logic [7:0] tx = 8'h00;
  logic [7:0] rx = 8'h00;
  int oi = 0;
  int si = 0;

  // Lines start quiet, enable inactive.
  initial begin
    miso = 1'b0;
    sclk_m = 1'b0;
    mosi_m = 1'b0;
    sel_n = 1'b1;
  end

  // A released data line flips every cycle so a stale bit never passes as data.
  always @(posedge aclk) begin
    if (!armed) miso <= ~miso;
  end

  // The clock line sits at its idle level before the port leaves soft reset.
  task automatic set_mode(input logic pl, input logic ph);
    cpol = pl;
    cpha = ph;
    sclk_m = pl;
  endtask : set_mode

  // Loads the reply; with phase 0 the first bit must stand before the first edge.
  task automatic arm(input logic [7:0] b);
    tx = b;
    rx = 8'h00;
    si = 0;
    oi = 7;
    armed = 1'b1;
    if (!cpha) begin
      miso = tx[7];
      oi = 6;
    end
  endtask : arm

  // Sample on the phase-selected edge and change on the other, MSB first.
  always @(sclk) begin
    if (armed && ((sclk != cpol) == !cpha)) begin
      rx = {rx[6:0], mosi};
      si++;
      armed = (si < 8);
    end else if (armed && oi >= 0) begin
      miso = tx[oi];
      oi--;
    end
  end

  // One frame as master: 15 ns half periods, clock still outside the frame.
  task automatic send(input logic [7:0] b, output logic [7:0] got);
    got = 8'h00;
    sel_n = 1'b0;
    #43;
    for (int i = 7; i >= 0; i--) begin
      if (!cpha) mosi_m = b[i];
      #15;
      if (!cpha) got = {got[6:0], miso_dut};
      sclk_m = ~cpol;
      if (cpha) mosi_m = b[i];
      #15;
      if (cpha) got = {got[6:0], miso_dut};
      sclk_m = cpol;
    end
    #15;
    mosi_m = ~mosi_m;
    #40;
    sel_n = 1'b1;
  endtask : send
endmodule : spc_peer

/* File: tb/spi_port_core_tb_top.sv */
// Self-checking bench for the serial peripheral port core.
module spi_port_core_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import spc_pkg::*;

  localparam int HALF = 5;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic awvalid, wvalid, bready, arvalid, rready;
  logic [3:0] awaddr, wstrb, araddr;
  logic [31:0] wdata, rdata, rd;
  logic awready, wready, bvalid, arready, rvalid, clk_request_q;
  logic [1:0] bresp, rresp, rs;
  logic spi_sclk_o, spi_sclk_oe, spi_miso_o, spi_miso_oe, spi_mosi_o, spi_mosi_oe;
  logic slave_enable_pin_n_o, slave_enable_pin_n_oe, miso_p, sclk_p, mosi_p, sel_p;
  wire logic spi_sclk_in, spi_miso_i, spi_mosi_i, slave_enable_pin_n_i;
  int failures = 0;
  int comparisons = 0;
  int hc = 0;
  logic sclk_d = 1'b0;

  always #5 aclk = ~aclk;

  // Each line shows whoever enables a driver on it, else the far side.
  assign spi_sclk_in = spi_sclk_oe ? spi_sclk_o : sclk_p;
  assign spi_miso_i = spi_miso_oe ? spi_miso_o : miso_p;
  assign spi_mosi_i = spi_mosi_oe ? spi_mosi_o : mosi_p;
  assign slave_enable_pin_n_i = slave_enable_pin_n_oe ? slave_enable_pin_n_o : sel_p;

  spc_core #(.HALF_CYC(HALF)) i_dut (
    .aclk, .aresetn, .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata, .wstrb,
    .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid, .rready, .rdata, .rresp,
    .spi_sclk_in, .spi_sclk_o, .spi_sclk_oe, .spi_miso_i, .spi_miso_o, .spi_miso_oe,
    .spi_mosi_i, .spi_mosi_o, .spi_mosi_oe, .slave_enable_pin_n_i, .slave_enable_pin_n_o,
    .slave_enable_pin_n_oe, .clk_request_q
  );

  spc_peer i_peer (
    .aclk, .sclk(spi_sclk_in), .mosi(spi_mosi_i), .miso_dut(spi_miso_i),
    .miso(miso_p), .sclk_m(sclk_p), .mosi_m(mosi_p), .sel_n(sel_p)
  );

  // ----------------------------------------------------------------
  // Checking and closing
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic wrap_up();
    $display("failures %0d comparisons %0d", failures, comparisons);
    if (failures == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : wrap_up

  // A wait that runs past its bound ends the run rather than hanging it.
  task automatic guard(input int n);
    if (n >= 200) begin
      chk("wait bound", 32'h0, 32'h1);
      wrap_up();
    end
  endtask : guard

  // Samples at the falling edge hold the value the rising edge will see.
  // Only a running master frame is timed; idle level changes are not half periods.
  always @(negedge aclk) begin
    sclk_d <= spi_sclk_o;
    if (clk_request_q !== 1'b1 || spi_sclk_oe !== 1'b1) begin
      hc <= 0;
    end else if (spi_sclk_o !== sclk_d) begin
      chk("half period", HALF, hc);
      hc <= 1;
    end else begin
      hc <= hc + 1;
    end
  end

  // ----------------------------------------------------------------
  // Register bus master
  // ----------------------------------------------------------------
  task automatic wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    logic pa, pw, ha, hw, hb;
    int n;
    @(posedge aclk);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= d;
    wstrb <= 4'h1;
    bready <= 1'b1;
    pa = 1'b1;
    pw = 1'b1;
    hb = 1'b0;
    n = 0;
    while (pa || pw) begin
      @(negedge aclk);
      ha = pa && awready;
      hw = pw && wready;
      @(posedge aclk);
      if (ha) awvalid <= 1'b0;
      if (hw) wvalid <= 1'b0;
      pa = pa && !ha;
      pw = pw && !hw;
      n++;
      guard(n);
    end
    while (!hb) begin
      @(negedge aclk);
      hb = bvalid;
      r = bresp;
      @(posedge aclk);
      n++;
      guard(n);
    end
    bready <= 1'b0;
  endtask : wr

  task automatic rdr(input logic [3:0] a, output logic [31:0] d);
    logic hs;
    int n;
    @(posedge aclk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    hs = 1'b0;
    n = 0;
    while (!hs) begin
      @(negedge aclk);
      hs = arready;
      @(posedge aclk);
      n++;
      guard(n);
    end
    arvalid <= 1'b0;
    hs = 1'b0;
    while (!hs) begin
      @(negedge aclk);
      hs = rvalid;
      d = rdata;
      @(posedge aclk);
      n++;
      guard(n);
    end
    rready <= 1'b0;
  endtask : rdr

  // Polls status until the chosen bit reads as wanted.
  task automatic poll(input int bit_no, input logic want);
    int n;
    n = 0;
    rdr(SPC_STAT_OFS, rd);
    while (rd[bit_no] !== want) begin
      rdr(SPC_STAT_OFS, rd);
      n++;
      guard(n);
    end
  endtask : poll

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  // Reset value, busy still clear after a transmit write in soft reset, write to a read-only place.
  task automatic t_regs();
    rdr(SPC_CTRL_OFS, rd);
    chk("ctrl reset", {26'h0, SPC_CTRL_RST}, rd);
    wr(SPC_TXB_OFS, 32'h5a, rs);
    repeat (12) @(posedge aclk);
    rdr(SPC_STAT_OFS, rd);
    chk("busy in soft reset", 32'h0, rd & 32'h4);
    wr(SPC_STAT_OFS, 32'h0, rs);
    chk("status write resp", {30'h0, SPC_RESP_SLVERR}, {30'h0, rs});
  endtask : t_regs

  // Conflict mode: loss of the bus aborts a frame, then a write must not start one.
  task automatic t_conflict();
    wr(SPC_CTRL_OFS, 32'h22, rs);
    wr(SPC_TXB_OFS, 32'ha5, rs);
    repeat (20) @(posedge aclk);
    i_peer.sel_n <= 1'b0;
    poll(SPC_S_BUSY, 1'b0);
    chk("abort flags", 32'h1, rd & 32'h7);
    wr(SPC_TXB_OFS, 32'h3c, rs);
    repeat (20) @(posedge aclk);
    rdr(SPC_STAT_OFS, rd);
    chk("blocked start", 32'h0, rd & 32'h4);
    wr(SPC_CTRL_OFS, 32'h1, rs);
    i_peer.sel_n <= 1'b1;
  endtask : t_conflict

  // Master frame in mode m with the enable pin driven as an output.
  task automatic t_master(input logic [1:0] m, input logic [7:0] b, input logic [7:0] r);
    i_peer.set_mode(m[1], m[0]);
    wr(SPC_CTRL_OFS, {26'h0, 2'b11, m, 2'b10}, rs);
    repeat (3) @(posedge aclk);
    @(negedge aclk);
    chk("sclk idle", {31'h0, m[1]}, {31'h0, spi_sclk_o});
    i_peer.arm(r);
    wr(SPC_TXB_OFS, {24'h0, b}, rs);
    rdr(SPC_STAT_OFS, rd);
    @(negedge aclk);
    chk("busy and tx ready", 32'h5, rd & 32'h7);
    chk("clock request on", 32'h1, {31'h0, clk_request_q});
    chk("enable out", 32'h2, {30'h0, slave_enable_pin_n_oe, slave_enable_pin_n_o});
    poll(SPC_S_RXDONE, 1'b1);
    @(negedge aclk);
    chk("done flags", 32'h3, rd & 32'h7);
    chk("clock request off", 32'h0, {31'h0, clk_request_q});
    chk("sclk back idle", {31'h0, m[1]}, {31'h0, spi_sclk_o});
    rdr(SPC_RXB_OFS, rd);
    chk("rx byte", {24'h0, r}, rd & 32'hff);
    chk("peer rx byte", {24'h0, b}, {24'h0, i_peer.rx});
    rdr(SPC_STAT_OFS, rd);
    chk("idle after read", 32'h1, rd & 32'h7);
  endtask : t_master

  // Slave frame in mode m after a set-then-clear of the soft reset bit.
  task automatic t_slave(input logic [1:0] m, input logic [7:0] b, input logic [7:0] r);
    logic [7:0] got;
    wr(SPC_CTRL_OFS, 32'h1, rs);
    i_peer.set_mode(m[1], m[0]);
    wr(SPC_CTRL_OFS, {28'h0, m, 2'b00}, rs);
    wr(SPC_TXB_OFS, {24'h0, r}, rs);
    i_peer.send(b, got);
    poll(SPC_S_RXDONE, 1'b1);
    // Busy follows the synchronised enable line, so it drops a few cycles after the frame.
    poll(SPC_S_BUSY, 1'b0);
    chk("slave flags", 32'h3, rd & 32'h7);
    rdr(SPC_RXB_OFS, rd);
    chk("slave rx byte", {24'h0, b}, rd & 32'hff);
    chk("slave tx byte", {24'h0, r}, {24'h0, got});
  endtask : t_slave

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {awaddr, wstrb, araddr} = 12'h000;
    wdata = 32'h0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_conflict();
    for (int i = 0; i < 4; i++) t_master(i[1:0], 8'ha5 ^ i[7:0], 8'h3c + i[7:0]);
    for (int i = 0; i < 4; i++) t_slave(i[1:0], 8'hc3 ^ i[7:0], 8'h81 | i[7:0]);
    wrap_up();
  end
endmodule : spi_port_core_tb_top
